/* File: core/nfsm_defs.svh */
`ifndef NFSM_DEFS_SVH
`define NFSM_DEFS_SVH
`define NFSM_PAR_POWER 3'h0
`define NFSM_PAR_UAF 3'h1
`define NFSM_PAR_DIF 3'h2
`define NFSM_PAR_DAF 3'h3
`define NFSM_PAR_UIF 3'h4
`define NFSM_TX_NONE 2'h0
`define NFSM_TX_NORMAL 2'h1
`define NFSM_TX_MAINT 2'h2
`endif

/* File: core/nfsm_pkg.sv */
package nfsm_pkg;
  typedef enum logic [3:0] {
    G0, G1, G2, G3, G4, G5, G6, G7, G8, G9, G10, G11, G12, G13
  } nfsm_state_t;
  typedef struct packed {
    logic power_loss;
    logic power_return;
    logic normal_cells;
    logic upstream_access_fault;
    logic downstream_iface_fault;
    logic downstream_access_fault;
    logic upstream_iface_fault;
  } nfsm_event_t;
  typedef struct packed {
    logic [1:0] kind;
    logic p_rdi;
    logic s_rdi;
    logic p_ais;
  } nfsm_tx_t;
  typedef struct packed {
    logic upper_active_ind;
    logic upper_deact_ind;
    logic mgmt_active_ind;
    logic mgmt_error_ind;
    logic mgmt_correct_ind;
    logic [2:0] param;
  } nfsm_ind_t;
endpackage

/* File: core/nfsm_top.sv */
`timescale 1ns/1ps
`include "nfsm_defs.svh"
// Function
// - fourteen states: power off, operational, eleven fault combinations, power on
// - maintenance signal transmitted is chosen per state
// - power loss goes to G0 with error zero; deactivate too when leaving G1
// - power return in G0 gives correction zero and enters G13
// - normal cells in G2..G13 return to G1 with both activate indications
// - upstream access fault gives error one and its transitions
// - downstream interface fault gives error two and its transitions
// - downstream access fault gives error three and its transitions
// - upstream interface fault gives error four and its transitions
// - leaving G1 on a fault also gives upper deactivate
// - error and correction indications carry the condition number
// - G13 is transient and left on the first assessed event other than an upstream interface fault or a power return
module nfsm_top (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire nfsm_pkg::nfsm_event_t EVT,
  output nfsm_pkg::nfsm_state_t STATE,
  output nfsm_pkg::nfsm_tx_t TX,
  output nfsm_pkg::nfsm_ind_t IND
);
  import nfsm_pkg::*;

  // ***********************************
  // input synchronisers
  // ***********************************
  nfsm_event_t evt_meta;
  nfsm_event_t evt_sync;
  nfsm_event_t evt_last;
  nfsm_event_t rise;
  nfsm_state_t next_state;
  nfsm_ind_t next_ind;
  logic [2:0] next_par;
  logic hit;

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      evt_meta <= '0;
      evt_sync <= '0;
      evt_last <= '0;
    end else if (CE) begin
      evt_meta <= EVT;
      evt_sync <= evt_meta;
      evt_last <= evt_sync;
    end
  end

  // new events are rising edges of the synchronised conditions
  assign rise = evt_sync & ~evt_last;

  // ***********************************
  // transition function
  // ***********************************
  function automatic nfsm_state_t fault_move(input logic [2:0] fc, input nfsm_state_t s);
    fault_move = s;
    case (fc)
      `NFSM_PAR_UAF: begin
        case (s)
          G1: fault_move = G2;
          G3: fault_move = G6;
          G4: fault_move = G7;
          G5: fault_move = G8;
          G9: fault_move = G11;
          G10: fault_move = G12;
          G13: fault_move = G2;
          default: fault_move = s;
        endcase
      end
      `NFSM_PAR_DIF: begin
        case (s)
          G1: fault_move = G3;
          G2: fault_move = G6;
          G4: fault_move = G9;
          G7: fault_move = G11;
          G13: fault_move = G3;
          default: fault_move = s;
        endcase
      end
      `NFSM_PAR_DAF: begin
        case (s)
          G1: fault_move = G4;
          G2: fault_move = G7;
          G3: fault_move = G9;
          G5: fault_move = G10;
          G6: fault_move = G11;
          G8: fault_move = G12;
          G13: fault_move = G4;
          default: fault_move = s;
        endcase
      end
      `NFSM_PAR_UIF: begin
        case (s)
          G1: fault_move = G5;
          G2: fault_move = G8;
          G3: fault_move = G5;
          G4: fault_move = G10;
          G6: fault_move = G8;
          G7: fault_move = G12;
          default: fault_move = s;
        endcase
      end
      default: fault_move = s;
    endcase
  endfunction

  always_comb begin
    next_state = STATE;
    next_ind = '0;
    next_par = 3'h0;
    hit = 1'b0;
    if (rise.power_loss) begin
      if (STATE != G0) begin
        next_state = G0;
        next_ind.mgmt_error_ind = 1'b1;
        next_ind.param = `NFSM_PAR_POWER;
        next_ind.upper_deact_ind = (STATE == G1);
      end
    end else if (rise.power_return) begin
      if (STATE == G0) begin
        next_state = G13;
        next_ind.mgmt_correct_ind = 1'b1;
        next_ind.param = `NFSM_PAR_POWER;
      end
    end else if (STATE != G0) begin
      if (rise.normal_cells) begin
        if (STATE != G1) begin
          next_state = G1;
          next_ind.upper_active_ind = 1'b1;
          next_ind.mgmt_active_ind = 1'b1;
        end
      end else begin
        if (rise.upstream_access_fault) begin
          next_par = `NFSM_PAR_UAF;
          hit = 1'b1;
        end else if (rise.downstream_iface_fault) begin
          next_par = `NFSM_PAR_DIF;
          hit = 1'b1;
        end else if (rise.downstream_access_fault) begin
          next_par = `NFSM_PAR_DAF;
          hit = 1'b1;
        end else if (rise.upstream_iface_fault) begin
          next_par = `NFSM_PAR_UIF;
          hit = 1'b1;
        end
        if (hit && fault_move(next_par, STATE) != STATE) begin
          next_state = fault_move(next_par, STATE);
          next_ind.mgmt_error_ind = 1'b1;
          next_ind.param = next_par;
          next_ind.upper_deact_ind = (STATE == G1);
        end
      end
    end
  end

  // ***********************************
  // state and indications
  // ***********************************
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      STATE <= G0;
    end else if (CE) begin
      STATE <= next_state;
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      IND <= '0;
    end else if (CE) begin
      IND <= next_ind;
    end
  end

  // ***********************************
  // transmitted signal
  // ***********************************
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      TX <= '0;
    end else if (CE) begin
      TX.p_rdi <= 1'b0;
      TX.s_rdi <= 1'b0;
      TX.p_ais <= 1'b0;
      TX.kind <= `NFSM_TX_MAINT;
      case (next_state)
        G0, G13: TX.kind <= `NFSM_TX_NONE;
        G1, G3: TX.kind <= `NFSM_TX_NORMAL;
        G2, G6: TX.p_rdi <= 1'b1;
        G4, G7, G9, G11: TX.p_ais <= 1'b1;
        G5, G8: begin
          TX.s_rdi <= 1'b1;
          TX.p_rdi <= 1'b1;
        end
        G10: begin
          TX.p_ais <= 1'b1;
          TX.s_rdi <= 1'b1;
        end
        G12: begin
          TX.p_ais <= 1'b1;
          TX.s_rdi <= 1'b1;
          TX.p_rdi <= 1'b1;
        end
        default: TX.kind <= `NFSM_TX_NONE;
      endcase
    end
  end
endmodule

/* File: sim/nfsm_user_end.sv */
`timescale 1ns/1ps
module nfsm_user_end
  import nfsm_pkg::*;
(
  input wire logic [2:0] sel,
  input wire logic fire,
  output nfsm_event_t evt
);
  // raises one condition level at a time; the others stay low
  assign evt = fire ? nfsm_event_t'(7'h01 << sel) : nfsm_event_t'(7'h00);
endmodule

/* File: sim/nfsm_asserts.sv */
`timescale 1ns/1ps
module nfsm_asserts
  import nfsm_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire nfsm_event_t EVT,
  input wire nfsm_state_t STATE,
  input wire nfsm_tx_t TX,
  input wire nfsm_ind_t IND
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_left_g1;
    $past(STATE) == G1 && STATE != G1;
  endsequence
  a_left_deact: assert property (s_left_g1 |-> IND.upper_deact_ind)
    else $error("no deact");
  a_deact_src: assert property (IND.upper_deact_ind |-> s_left_g1)
    else $error("stray deact");
  a_off_err: assert property ($past(STATE) != G0 && STATE == G0 |->
    IND.mgmt_error_ind && IND.param == 3'h0) else $error("bad off");
  a_on_corr: assert property ($past(STATE) != G13 && STATE == G13 |->
    IND.mgmt_correct_ind && IND.param == 3'h0) else $error("bad on");
  a_back_g1: assert property ($past(STATE) != G1 && STATE == G1 |->
    IND.upper_active_ind && IND.mgmt_active_ind) else $error("bad act");
  a_fault_err: assert property (STATE != $past(STATE) && !(STATE inside {G0, G1, G13})
    |-> IND.mgmt_error_ind) else $error("no err");
  a_ce_hold: assert property (!CE |=> $stable(STATE) && $stable(IND))
    else $error("moved while frozen");
  a_quiet_ind: assert property (CE && STATE == $past(STATE) |-> IND == 8'h00)
    else $error("stray ind");
  a_tx_none: assert property (STATE == G0 || STATE == G13 |-> TX == 5'h00)
    else $error("bad tx");
endmodule
bind nfsm_top nfsm_asserts u_chk (.CLK, .RESET, .CE, .EVT, .STATE, .TX, .IND);

/* File: sim/nfsm_top_bench.sv */
`timescale 1ns/1ps
module nfsm_top_bench;
  import nfsm_pkg::*;
  logic CLK, RESET, CE, fire;
  logic [2:0] sel;
  nfsm_event_t EVT;
  nfsm_state_t STATE;
  nfsm_tx_t TX;
  nfsm_ind_t IND;
  int miscompares, cmp_count;
  nfsm_user_end u_far (.sel(sel), .fire(fire), .evt(EVT));
  nfsm_top u_dut (.CLK, .RESET, .CE, .EVT, .STATE, .TX, .IND);
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  function automatic logic [4:0] tx_of(nfsm_state_t s);
    case (s)
      G0, G13: return 5'h00;
      G1, G3: return 5'h08;
      G2, G6: return 5'h14;
      G5, G8: return 5'h16;
      G10: return 5'h13;
      G12: return 5'h17;
      default: return 5'h11;
    endcase
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // raise one level, judge the answer one edge after it is synchronised
  task automatic go(int idx, nfsm_state_t s, logic [7:0] ind);
    @(negedge CLK) sel = idx[2:0];
    fire = 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    chk({4'h0, STATE}, {4'h0, s});
    chk({3'h0, TX}, {3'h0, tx_of(s)});
    chk(IND, ind);
    @(negedge CLK) fire = 1'b0;
    repeat (3) @(negedge CLK);
  endtask
  task automatic t_a;
    go(5, G13, 8'h08);
    go(4, G1, 8'ha0);
    go(4, G1, 8'h00);
    go(3, G2, 8'h51);
    go(2, G6, 8'h12);
    go(1, G11, 8'h13);
    go(3, G11, 8'h00);
    go(6, G0, 8'h10);
    go(6, G0, 8'h00);
    $display("test a done");
  endtask
  task automatic t_b;
    go(5, G13, 8'h08);
    go(2, G3, 8'h12);
    go(0, G5, 8'h14);
    go(2, G5, 8'h00);
    go(1, G10, 8'h13);
    go(3, G12, 8'h11);
    go(4, G1, 8'ha0);
    go(6, G0, 8'h50);
    $display("test b done");
  endtask
  task automatic t_c;
    go(5, G13, 8'h08);
    go(1, G4, 8'h13);
    go(0, G10, 8'h14);
    go(4, G1, 8'ha0);
    go(0, G5, 8'h54);
    go(3, G8, 8'h11);
    go(4, G1, 8'ha0);
    go(2, G3, 8'h52);
    $display("test c done");
  endtask
  // clock enable low must freeze synchronisers and state
  task automatic t_d;
    @(negedge CLK) CE = 1'b0;
    sel = 3'h4;
    fire = 1'b1;
    repeat (6) @(posedge CLK);
    #1;
    chk({4'h0, STATE}, {4'h0, G3});
    chk(IND, 8'h00);
    @(negedge CLK) CE = 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    chk({4'h0, STATE}, {4'h0, G1});
    chk(IND, 8'ha0);
    @(negedge CLK) fire = 1'b0;
    repeat (3) @(negedge CLK);
    $display("test d done");
  endtask
  task automatic end_of_test;
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    RESET = 1'b1;
    CE = 1'b1;
    fire = 1'b0;
    sel = 3'h0;
    repeat (5) @(posedge CLK);
    @(negedge CLK) RESET = 1'b0;
    t_a();
    t_b();
    t_c();
    t_d();
    end_of_test();
  end
  initial begin
    #20000;
    miscompares++;
    end_of_test();
  end
endmodule
